// ### usr_pkg.sv
package usr_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          USR_ADDR_W   = 12;
    localparam logic [11:0] USR_OFS_CTRL = 12'h000;
    localparam logic [11:0] USR_OFS_CMD  = 12'h004;
    localparam logic [11:0] USR_OFS_STAT = 12'h008;
    localparam logic [11:0] USR_OFS_FLAG = 12'h00C;
    localparam logic [11:0] USR_OFS_STEP = 12'h010;

    // Control register fields and reset value.
    localparam int          USR_CTRL_RUN   = 0;
    localparam int          USR_CTRL_CLR_N = 1;
    localparam logic [1:0]  USR_CTRL_RST   = 2'h3;

    // Command word layout.
    localparam int          USR_STAGES   = 4;
    localparam int          USR_CMD_W    = 8;
    localparam int          USR_CMD_DLO  = 0;
    localparam int          USR_CMD_DHI  = 3;
    localparam int          USR_CMD_SRL  = 4;
    localparam int          USR_CMD_SRF  = 5;
    localparam int          USR_CMD_MS0  = 6;
    localparam int          USR_CMD_MS1  = 7;

    // Flag register fields.
    localparam int          USR_FLAG_EMPTY = 0;
    localparam int          USR_FLAG_FULL  = 1;
    localparam int          USR_FLAG_OVF   = 2;
    localparam int          USR_FLAG_LVLLO = 8;
    localparam int          USR_FLAG_LVLHI = 12;

    // Command buffer shape and step counter width.
    localparam int          USR_FIFO_DEPTH = 16;
    localparam int          USR_LVL_W      = 5;
    localparam int          USR_STEP_W     = 16;
    localparam logic [15:0] USR_STEP_ONE   = 16'h0001;

    // Mode selected by {mode_select_high, mode_select_low}.
    typedef enum logic [1:0] {
        USR_MODE_HOLD  = 2'b00,
        USR_MODE_LAST  = 2'b01,
        USR_MODE_FIRST = 2'b10,
        USR_MODE_LOAD  = 2'b11
    } usr_mode_t;

    // Sequencer states, Gray coded along idle, run, clear.
    typedef enum logic [1:0] {
        USR_ST_IDLE  = 2'b00,
        USR_ST_RUN   = 2'b01,
        USR_ST_CLEAR = 2'b11
    } usr_state_t;

endpackage : usr_pkg

// ### usr_fifo.sv
module usr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire logic [WIDTH-1:0]   in_data,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output logic [WIDTH-1:0]        out_data,
    output logic [$clog2(DEPTH):0]  level
);

    // ------------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------------
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);
    localparam logic [PW:0]   PFULL = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] PINC  = PW'(1);
    localparam logic [PW:0]   CINC  = (PW + 1)'(1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;
    wire              push;
    wire              pop;

    // Honest full and empty straight from the occupancy count.
    assign in_ready  = (count_ff != PFULL);
    assign out_valid = (count_ff != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_ff[rd_ptr_ff];
    assign level     = count_ff;

    // Write side stores a word and advances the write pointer.
    always_ff @(posedge pclk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers wrap at the last slot; count follows push and pop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PLAST) ? '0 : wr_ptr_ff + PINC;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PLAST) ? '0 : rd_ptr_ff + PINC;
            end
            if (push && !pop) begin
                count_ff <= count_ff + CINC;
            end else if (pop && !push) begin
                count_ff <= count_ff - CINC;
            end
        end
    end

endmodule : usr_fifo

// ### usr_shift_reg.sv
// Implementation choices: the register addresses and register access over APB.
module usr_shift_reg
    import usr_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [USR_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        stage_out_0,
    output logic                        stage_out_1,
    output logic                        stage_out_2,
    output logic                        stage_out_3
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Registers of the block.
    logic [1:0]             ctrl_ff;
    logic                   ovf_ff;
    logic [USR_STAGES-1:0]  stage_ff;
    logic [USR_STEP_W-1:0]  step_cnt_ff;
    logic [31:0]            prdata_ff;

    // Sequencer state and next values.
    usr_state_t             state_ff;
    usr_state_t             nxt_state;
    logic [USR_STAGES-1:0]  nxt_stage;
    logic [31:0]            nxt_rdata;

    // Nets of the command buffer.
    wire                    fifo_in_ready;
    wire                    fifo_out_valid;
    wire [USR_CMD_W-1:0]    fifo_out_data;
    wire [USR_LVL_W-1:0]    fifo_level;

    // ------------------------------------------------------------------
    // Mode decoding
    // ------------------------------------------------------------------

    // Maps a command word to its mode from the two mode selects.
    // Mode codes equal the select pair.
    function automatic usr_mode_t usr_decode_mode(
        input logic [USR_CMD_W-1:0] cmd
    );
        usr_mode_t m;
        case ({cmd[USR_CMD_MS1], cmd[USR_CMD_MS0]})
            USR_MODE_LAST: begin
                m = USR_MODE_LAST;
            end
            USR_MODE_FIRST: begin
                m = USR_MODE_FIRST;
            end
            USR_MODE_LOAD: begin
                m = USR_MODE_LOAD;
            end
            default: begin
                m = USR_MODE_HOLD;
            end
        endcase
        return m;
    endfunction : usr_decode_mode

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------

    // Setup and access phase qualifiers.
    // Writes change state only in the access phase; read data loads in setup.
    wire setup_ph  = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_acc    = access_ph & pwrite;

    // Address hits, one per register.
    wire hit_ctrl  = (paddr == USR_OFS_CTRL);
    wire hit_cmd   = (paddr == USR_OFS_CMD);
    wire hit_stat  = (paddr == USR_OFS_STAT);
    wire hit_flag  = (paddr == USR_OFS_FLAG);
    wire hit_step  = (paddr == USR_OFS_STEP);
    wire hit_any   = hit_ctrl | hit_cmd | hit_stat | hit_flag | hit_step;

    // The command port is write only; a read of it counts as unmapped.
    // Writes to read-only words are ignored.
    wire bad_addr  = ~hit_any | (hit_cmd & ~pwrite);

    // A command write into a full buffer is refused and flagged.
    wire cmd_wr    = wr_acc & hit_cmd;
    wire cmd_push  = cmd_wr & fifo_in_ready;
    wire cmd_drop  = cmd_wr & ~fifo_in_ready;

    // Control and flag writes; a one clears overflow.
    wire ctrl_wr   = wr_acc & hit_ctrl;
    wire flag_wr   = wr_acc & hit_flag;
    wire ovf_clr   = flag_wr & pwdata[USR_FLAG_OVF];

    // Zero wait states; errors only in the access phase.
    // No transfer is ever stretched.
    assign pready  = 1'b1;
    assign pslverr = access_ph & (bad_addr | cmd_drop);

    // Read data comes straight from its register.
    assign prdata  = prdata_ff;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------

    // Run gates stepping; clear_n low holds the register cleared.
    // Both fields come out of reset set.
    wire run_en    = ctrl_ff[USR_CTRL_RUN];
    wire clear_act = ~ctrl_ff[USR_CTRL_CLR_N];

    // ------------------------------------------------------------------
    // Step sequencing
    // ------------------------------------------------------------------

    // A step is one command taken from the buffer; none while clearing.
    // One step is one edge of the shift register.
    wire step = (state_ff == USR_ST_RUN) & fifo_out_valid & ~clear_act;

    // The sequencer follows clear first, then run; buffered work only gates the step.
    // Leaving clear passes through idle, so no
    // command runs on the edge that releases it.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            USR_ST_IDLE: begin
                // Waits for run; clear is honoured first.
                if (clear_act) begin
                    nxt_state = USR_ST_CLEAR;
                end else if (run_en) begin
                    nxt_state = USR_ST_RUN;
                end
            end
            USR_ST_RUN: begin
                // Stops on clear or when run falls.
                if (clear_act) begin
                    nxt_state = USR_ST_CLEAR;
                end else if (!run_en) begin
                    nxt_state = USR_ST_IDLE;
                end
            end
            USR_ST_CLEAR: begin
                // Stays until clear is released.
                if (!clear_act) begin
                    nxt_state = USR_ST_IDLE;
                end
            end
            default: begin
                nxt_state = USR_ST_IDLE;
            end
        endcase
    end

    // State register of the sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= USR_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Command buffer
    // ------------------------------------------------------------------

    // Sixteen buffered commands; draining stalls when not stepping.
    // A write into a full buffer is refused with an
    // error, so no command is lost unseen.
    usr_fifo #(
        .WIDTH (USR_CMD_W),
        .DEPTH (USR_FIFO_DEPTH)
    ) u_cmd_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (cmd_push),
        .in_ready  (fifo_in_ready),
        .in_data   (pwdata[USR_CMD_W-1:0]),
        .out_valid (fifo_out_valid),
        .out_ready (step),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // ------------------------------------------------------------------
    // Stage next values
    // ------------------------------------------------------------------

    // Fields of the command at the head of the buffer.
    // They stand until the command is consumed.
    wire [USR_STAGES-1:0] par_data = fifo_out_data[USR_CMD_DHI:USR_CMD_DLO];
    wire       ser_last  = fifo_out_data[USR_CMD_SRL];
    wire       ser_first = fifo_out_data[USR_CMD_SRF];
    usr_mode_t head_mode;
    assign head_mode = usr_decode_mode(fifo_out_data);

    // Neighbour feeding each stage, serial bits at the two ends.
    // Bit zero enters the first stage.
    wire [USR_STAGES+1:0] chain = {ser_first, stage_ff, ser_last};

    // One selector per stage picks its next value from the mode.
    // Toward last, stage i takes chain[i]; toward
    // first, it takes chain[i+2].
    genvar gi;
    generate
        for (gi = 0; gi < USR_STAGES; gi++) begin : g_stage
            always_comb begin
                case (head_mode)
                    USR_MODE_LOAD: begin
                        nxt_stage[gi] = par_data[gi];
                    end
                    USR_MODE_LAST: begin
                        nxt_stage[gi] = chain[gi];
                    end
                    USR_MODE_FIRST: begin
                        nxt_stage[gi] = chain[gi+2];
                    end
                    default: begin
                        nxt_stage[gi] = stage_ff[gi];
                    end
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Stage register
    // ------------------------------------------------------------------

    // Clear wins; otherwise only a step changes the stages.
    // Commands wait in the buffer while clear
    // is active instead of being consumed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_ff <= '0;
        end else if (clear_act) begin
            stage_ff <= '0;
        end else if (step) begin
            stage_ff <= nxt_stage;
        end
    end

    // Outputs fall in the same cycle as clear, before any edge.
    // Without the gate they would fall only one edge after the
    // write that sets clear.
    wire [USR_STAGES-1:0] stage_vis = clear_act ? '0 : stage_ff;

    // Stage zero is the first stage.
    assign stage_out_0 = stage_vis[0];
    assign stage_out_1 = stage_vis[1];
    assign stage_out_2 = stage_vis[2];
    assign stage_out_3 = stage_vis[3];

    // ------------------------------------------------------------------
    // Step counter
    // ------------------------------------------------------------------

    // Counts executed steps of every mode; clear restarts it.
    // Hold commands count too, as they are consumed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt_ff <= '0;
        end else if (clear_act) begin
            step_cnt_ff <= '0;
        end else if (step) begin
            step_cnt_ff <= step_cnt_ff + USR_STEP_ONE;
        end
    end

    // ------------------------------------------------------------------
    // Control and flag registers
    // ------------------------------------------------------------------

    // Control register written whole from the low bits.
    // Software may set run and clear together.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= USR_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_ff <= pwdata[USR_CTRL_CLR_N:USR_CTRL_RUN];
        end
    end

    // Sticky overflow, cleared by writing one; a new drop wins.
    // It tells software a command was lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_ff <= 1'b0;
        end else if (cmd_drop) begin
            ovf_ff <= 1'b1;
        end else if (ovf_clr) begin
            ovf_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------

    // Read word selected during setup so it stands in the access phase.
    // Loading in setup lets prdata come from a
    // flip-flop yet stand in the access phase.
    always_comb begin
        nxt_rdata = '0;
        if (hit_ctrl) begin
            nxt_rdata[USR_CTRL_CLR_N:USR_CTRL_RUN] = ctrl_ff;
        end else if (hit_stat) begin
            nxt_rdata[USR_STAGES-1:0] = stage_vis;
        end else if (hit_flag) begin
            nxt_rdata[USR_FLAG_EMPTY] = ~fifo_out_valid;
            nxt_rdata[USR_FLAG_FULL]  = ~fifo_in_ready;
            nxt_rdata[USR_FLAG_OVF]   = ovf_ff;
            nxt_rdata[USR_FLAG_LVLHI:USR_FLAG_LVLLO] = fifo_level;
        end else if (hit_step) begin
            nxt_rdata[USR_STEP_W-1:0] = step_cnt_ff;
        end
    end

    // Read data register loaded on the setup cycle of a read.
    // It keeps its word until the next read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (setup_ph && !pwrite) begin
            prdata_ff <= nxt_rdata;
        end
    end

endmodule : usr_shift_reg

// ### usr_shift_reg_checker.sv
module usr_shift_reg_checker
    import usr_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [USR_ADDR_W-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  stage_out_0,
    input wire logic                  stage_out_1,
    input wire logic                  stage_out_2,
    input wire logic                  stage_out_3
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------
    // Helper state
    // ----------------------------------------------------------
    logic [3:0] st;
    logic [3:0] nxt_exp;
    logic [3:0] exp_ff;
    logic [4:0] quiet_ff;
    logic       run_ff;
    logic       clrn_ff;
    logic       push;
    logic       ctrl_wr;
    logic       bad;
    logic [1:0] md;

    // Decode of the bus and the stage value a command should give.
    assign st = {stage_out_3, stage_out_2, stage_out_1, stage_out_0};
    assign push = psel && penable && pwrite && paddr == USR_OFS_CMD;
    assign ctrl_wr = psel && penable && pwrite && paddr == USR_OFS_CTRL;
    assign bad = !(paddr inside {USR_OFS_CTRL, USR_OFS_CMD, USR_OFS_STAT,
                 USR_OFS_FLAG, USR_OFS_STEP})
                 || (!pwrite && paddr == USR_OFS_CMD);
    assign md = pwdata[7:6];
    assign nxt_exp = (md == USR_MODE_LOAD) ? pwdata[3:0] :
                     (md == USR_MODE_LAST) ? {st[2:0], pwdata[4]} :
                     (md == USR_MODE_FIRST) ? {pwdata[5], st[3:1]} : st;

    // Quiet count proves the buffer has drained before a fresh push.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= 1'b1;
            clrn_ff <= 1'b1;
            quiet_ff <= 5'h00;
            exp_ff <= 4'h0;
        end else begin
            if (ctrl_wr) begin
                run_ff <= pwdata[0];
                clrn_ff <= pwdata[1];
            end
            if (push || !(run_ff && clrn_ff)) begin
                quiet_ff <= 5'h00;
            end else if (quiet_ff != 5'h1f) begin
                quiet_ff <= quiet_ff + 5'h01;
            end
            if (push) begin
                exp_ff <= nxt_exp;
            end
        end
    end

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A command pushed into an empty, running buffer.
    sequence s_fresh_push;
        push && quiet_ff >= 5'h14;
    endsequence

    a_load_lands: assert property (
        s_fresh_push ##0 md == USR_MODE_LOAD |-> ##2 st == exp_ff)
        else $error("load did not land");
    a_shift_last: assert property (
        s_fresh_push ##0 md == USR_MODE_LAST |-> ##2 st == exp_ff)
        else $error("shift toward last wrong");
    a_shift_first: assert property (
        s_fresh_push ##0 md == USR_MODE_FIRST |-> ##2 st == exp_ff)
        else $error("shift toward first wrong");
    a_hold_keeps: assert property (
        s_fresh_push ##0 md == USR_MODE_HOLD |-> ##1 $stable(st) [*2])
        else $error("hold changed stages");
    a_clear_low: assert property (
        !clrn_ff |-> st == 4'h0)
        else $error("stages not low in clear");
    a_stall_holds: assert property (
        !run_ff && !$past(run_ff) && clrn_ff && !ctrl_wr |=> $stable(st))
        else $error("stages moved while stalled");
    a_stat_mirror: assert property (
        psel && !penable && !pwrite && paddr == USR_OFS_STAT
        |=> prdata[3:0] == $past(st))
        else $error("status read differs from stages");
    a_unmapped_err: assert property (
        psel && penable && bad |-> pslverr && pready)
        else $error("bad access not flagged");
endmodule : usr_shift_reg_checker

bind usr_shift_reg usr_shift_reg_checker usr_shift_reg_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stage_out_0(stage_out_0),
    .stage_out_1(stage_out_1), .stage_out_2(stage_out_2),
    .stage_out_3(stage_out_3));

// ### usr_host_model.sv
module usr_host_model
    import usr_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  pready,
    input  wire logic                  pslverr,
    input  wire logic [31:0]           prdata,
    output logic                       psel,
    output logic                       penable,
    output logic                       pwrite,
    output logic [USR_ADDR_W-1:0]      paddr,
    output logic [31:0]                pwdata,
    output logic                       hung
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idles with no request at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
        hung = 1'b0;
    end

    // One APB transfer; the word stays whole and stable until ready.
    task apb_xfer(input logic w, input logic [11:0] a,
                  input logic [31:0] d, output logic [31:0] rd,
                  output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) begin
            hung = 1'b1;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : apb_xfer
endmodule : usr_host_model

// ### universal_shift_register_4bit_tb.sv
module universal_shift_register_4bit_tb
    import usr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [USR_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [3:0]            so;
    logic                  hung;
    logic [31:0]           rd;
    logic                  er;
    int                    fails;
    int                    compares;
    logic [11:0]           rows [8] = '{12'hFAA, 12'h555, 12'h40A,
                               12'hA0D, 12'h9F6, 12'h3F6, 12'hC00, 12'hCFF};

    usr_shift_reg usr_shift_reg_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stage_out_0(so[0]),
        .stage_out_1(so[1]), .stage_out_2(so[2]), .stage_out_3(so[3]));

    usr_host_model usr_host_model_inst (
        .pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .hung(hung));

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    task print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk

    // Runs one transfer and ends the run if the bus hangs.
    task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        usr_host_model_inst.apb_xfer(w, a, d, rd, er);
        if (hung) begin
            fails++;
            print_verdict();
        end
    endtask : xf

    // Clock and watchdog.
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        print_verdict();
    end

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            repeat (24) @(posedge pclk);
            xf(1'b1, USR_OFS_CMD, {24'h00_0000, rows[i][11:4]});
            repeat (2) @(posedge pclk);
            #1 chk({28'h0, so}, {28'h0, rows[i][3:0]});
        end
        $display("mode table done");
        xf(1'b1, USR_OFS_CTRL, 32'h0000_0001);
        #1 chk({28'h0, so}, 32'h0000_0000);
        xf(1'b1, USR_OFS_CMD, 32'h0000_00C9);
        repeat (5) @(posedge pclk);
        chk({28'h0, so}, 32'h0000_0000);
        xf(1'b0, USR_OFS_STEP, 32'h0);
        chk(rd, 32'h0000_0000);
        xf(1'b1, USR_OFS_CTRL, 32'h0000_0003);
        repeat (4) @(posedge pclk);
        chk({28'h0, so}, 32'h0000_0009);
        $display("clear test done");
        xf(1'b1, USR_OFS_CTRL, 32'h0000_0002);
        for (int i = 0; i < 17; i++) begin
            xf(1'b1, USR_OFS_CMD, 32'h0000_0040 | ((i & 1) << 4));
            chk({31'h0, er}, {31'h0, i == 16});
        end
        chk({28'h0, so}, 32'h0000_0009);
        xf(1'b0, USR_OFS_FLAG, 32'h0);
        chk(rd, 32'h0000_1006);
        xf(1'b1, USR_OFS_CTRL, 32'h0000_0003);
        repeat (24) @(posedge pclk);
        chk({28'h0, so}, 32'h0000_0005);
        xf(1'b0, USR_OFS_FLAG, 32'h0);
        chk(rd, 32'h0000_0005);
        xf(1'b1, USR_OFS_FLAG, 32'h0000_0004);
        xf(1'b0, USR_OFS_FLAG, 32'h0);
        chk(rd, 32'h0000_0001);
        xf(1'b0, USR_OFS_STEP, 32'h0);
        chk(rd, 32'h0000_0011);
        $display("buffer test done");
        xf(1'b0, 12'h014, 32'h0);
        chk({rd[30:0], er}, 32'h0000_0001);
        xf(1'b0, USR_OFS_CMD, 32'h0);
        chk({31'h0, er}, 32'h0000_0001);
        xf(1'b1, USR_OFS_STAT, 32'h0);
        chk({31'h0, er}, 32'h0000_0000);
        xf(1'b0, USR_OFS_STAT, 32'h0);
        chk(rd, 32'h0000_0005);
        $display("access test done");
        @(posedge pclk);
        presetn <= 1'b0;
        #1 chk({28'h0, so}, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        xf(1'b0, USR_OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_0003);
        xf(1'b0, USR_OFS_FLAG, 32'h0);
        chk(rd, 32'h0000_0001);
        xf(1'b0, USR_OFS_STEP, 32'h0);
        chk(rd, 32'h0000_0000);
        $display("reset test done");
        print_verdict();
    end
endmodule : universal_shift_register_4bit_tb
